// file: rtl/debug_breakpoint_watchpoint_unit.v
// debug breakpoint, watchpoint, thread stop and mailbox logic behind a wishbone slave
//
// Contract
// - data watch hit captures access effective address
// - resource watch hit captures resource identifier
// - stop vector blocks thread issue outside debug
// - eight mailbox words, also on config port
// - four instruction breakpoints on PC match
// - per-thread enable field gates every unit
// - control bit1 selects equal or not-equal
// - bit0 master enable; controls reset zero
// - data watch has two independent addresses
// - control bit2 lets loads trigger
// - control bit1 combines A AND/OR B
// - resource watch mask and value registers
// - resource bit1 picks condition A or B
// - simultaneous hits of one kind report lowest unit number; breakpoint beats data watch beats resource watch
// - cause codes three, four, five recorded
`timescale 1ns/100ps
`default_nettype none
`include "debug_watch_regs.vh"

module debug_breakpoint_watchpoint_unit #(
    parameter THREADS = 8,
    parameter UNITS = 4,
    parameter MAILBOX_WORDS = 8
) (
    input wire mclk,
    input wire rst,
    // wishbone classic slave
    input wire wbCyc,
    input wire wbStb,
    input wire wbWe,
    input wire [9:0] wbAdr,
    input wire [3:0] wbSel,
    input wire [31:0] wbDatIn,
    output reg [31:0] wbDatOut,
    output reg wbAck,
    // tile configuration port onto the mailbox words
    input wire cfgEn,
    input wire cfgWe,
    input wire [2:0] cfgAddr,
    input wire [31:0] cfgWdata,
    output reg [31:0] cfgRdata,
    // pipeline observation
    input wire pcValid,
    input wire [2:0] pcThread,
    input wire [31:0] pcValue,
    input wire memValid,
    input wire memIsLoad,
    input wire [2:0] memThread,
    input wire [31:0] memAddr,
    input wire resValid,
    input wire [2:0] resThread,
    input wire [31:0] resId,
    // pipeline control
    output reg debugTrap,
    output reg debugMode,
    output reg [7:0] threadIssueBlock,
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////////
    // storage

    reg [31:0] mailbox [0:MAILBOX_WORDS-1];
    reg [31:0] ibAddr [0:UNITS-1];
    reg [31:0] ibCtrl [0:UNITS-1];
    reg [31:0] dwFirst [0:UNITS-1];
    reg [31:0] dwSecond [0:UNITS-1];
    reg [31:0] dwCtrl [0:UNITS-1];
    reg [31:0] rwMask [0:UNITS-1];
    reg [31:0] rwValue [0:UNITS-1];
    reg [31:0] rwCtrl [0:UNITS-1];
    reg [31:0] cause;
    reg [31:0] capture;
    reg [7:0] stopVector;
    reg [2:0] irqStatus;
    reg [2:0] irqMask;

    function [31:0] byteMerge;
        input [31:0] old;
        input [31:0] din;
        input [3:0] sel;
        input [31:0] writable;
        integer b;
        begin
            byteMerge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    byteMerge[b*8 +: 8] = din[b*8 +: 8];
                end
            end
            byteMerge = byteMerge & writable;
        end
    endfunction

    function [1:0] lowestHit;
        input [3:0] hits;
        begin
            if (hits[0]) begin
                lowestHit = 2'd0;
            end else if (hits[1]) begin
                lowestHit = 2'd1;
            end else if (hits[2]) begin
                lowestHit = 2'd2;
            end else begin
                lowestHit = 2'd3;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // match logic, one slice per unit

    wire [UNITS-1:0] ibHit;
    wire [UNITS-1:0] dwHit;
    wire [UNITS-1:0] rwHit;

    genvar u;
    generate
        for (u = 0; u < UNITS; u = u + 1) begin : gUnit
            wire pcEq = (pcValue == ibAddr[u]);
            wire pcCond = ibCtrl[u][`CTRL_SELECT_BIT] ? !pcEq : pcEq;
            assign ibHit[u] = pcValid && ibCtrl[u][`CTRL_ENABLE_BIT]
                && ibCtrl[u][`CTRL_THREAD_LSB + pcThread] && pcCond;

            wire dwA = (memAddr == dwFirst[u]);
            wire dwB = (memAddr == dwSecond[u]);
            wire dwCond = dwCtrl[u][`CTRL_SELECT_BIT] ? (dwA || dwB) : (dwA && dwB);
            // stores are always watched; loads only when asked for
            wire dwKind = !memIsLoad || dwCtrl[u][`CTRL_LOAD_BIT];
            assign dwHit[u] = memValid && dwCtrl[u][`CTRL_ENABLE_BIT]
                && dwCtrl[u][`CTRL_THREAD_LSB + memThread] && dwKind && dwCond;

            wire rwA = ((resId & rwMask[u]) == (rwValue[u] & rwMask[u]));
            wire rwB = (resId == rwValue[u]);
            wire rwCond = rwCtrl[u][`CTRL_SELECT_BIT] ? rwB : rwA;
            assign rwHit[u] = resValid && rwCtrl[u][`CTRL_ENABLE_BIT]
                && rwCtrl[u][`CTRL_THREAD_LSB + resThread] && rwCond;
        end
    endgenerate

    // no new trap while already in debug mode, so the record is not overwritten
    wire anyIb = |ibHit && !debugMode;
    wire anyDw = |dwHit && !debugMode;
    wire anyRw = |rwHit && !debugMode;
    wire trapNow = anyIb || anyDw || anyRw;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode

    wire [7:0] idx = wbAdr[9:2];
    wire busReq = wbCyc && wbStb && !wbAck;
    wire busWr = busReq && wbWe;
    wire [1:0] sub = idx[1:0];
    wire [2:0] mbSub = idx[2:0];

    wire selCause = (idx == `IDX_CAUSE);
    wire selCapture = (idx == `IDX_CAPTURE);
    wire selStop = (idx == `IDX_STOP);
    wire selState = (idx == `IDX_DBGSTATE);
    wire selIrqSt = (idx == `IDX_IRQ_STATUS);
    wire selIrqMk = (idx == `IDX_IRQ_MASK);
    wire selMb = (idx >= `IDX_MAILBOX_LO) && (idx <= `IDX_MAILBOX_HI);
    wire selIbA = (idx >= `IDX_IB_ADDR_LO) && (idx <= `IDX_IB_ADDR_HI);
    wire selIbC = (idx >= `IDX_IB_CTRL_LO) && (idx <= `IDX_IB_CTRL_HI);
    wire selDw1 = (idx >= `IDX_DW_FIRST_LO) && (idx <= `IDX_DW_FIRST_HI);
    wire selDw2 = (idx >= `IDX_DW_SECOND_LO) && (idx <= `IDX_DW_SECOND_HI);
    wire selDwC = (idx >= `IDX_DW_CTRL_LO) && (idx <= `IDX_DW_CTRL_HI);
    wire selRwM = (idx >= `IDX_RW_MASK_LO) && (idx <= `IDX_RW_MASK_HI);
    wire selRwV = (idx >= `IDX_RW_VALUE_LO) && (idx <= `IDX_RW_VALUE_HI);
    wire selRwC = (idx >= `IDX_RW_CTRL_LO) && (idx <= `IDX_RW_CTRL_HI);
    wire [1:0] rwSub = idx[1:0] - 2'd0;

    reg [31:0] next_rdata;
    always @* begin
        next_rdata = `RESET_ZERO;
        if (selCause) begin
            next_rdata = cause;
        end else if (selCapture) begin
            next_rdata = capture;
        end else if (selStop) begin
            next_rdata = {24'h00_0000, stopVector};
        end else if (selState) begin
            next_rdata = {31'h0, debugMode};
        end else if (selIrqSt) begin
            next_rdata = {29'h0, irqStatus};
        end else if (selIrqMk) begin
            next_rdata = {29'h0, irqMask};
        end else if (selMb) begin
            next_rdata = mailbox[mbSub];
        end else if (selIbA) begin
            next_rdata = ibAddr[sub];
        end else if (selIbC) begin
            next_rdata = ibCtrl[sub];
        end else if (selDw1) begin
            next_rdata = dwFirst[sub];
        end else if (selDw2) begin
            next_rdata = dwSecond[sub];
        end else if (selDwC) begin
            next_rdata = dwCtrl[sub];
        end else if (selRwM) begin
            next_rdata = rwMask[sub];
        end else if (selRwV) begin
            next_rdata = rwValue[sub];
        end else if (selRwC) begin
            next_rdata = rwCtrl[rwSub];
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            wbAck <= 1'b0;
            wbDatOut <= `RESET_ZERO;
        end else begin
            wbAck <= busReq;
            wbDatOut <= busReq ? next_rdata : `RESET_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watch unit registers

    integer i;
    integer j;
    always @(posedge mclk) begin
        if (rst) begin
            for (i = 0; i < UNITS; i = i + 1) begin
                ibAddr[i] <= `RESET_ZERO;
                ibCtrl[i] <= `RESET_ZERO;
                dwFirst[i] <= `RESET_ZERO;
                dwSecond[i] <= `RESET_ZERO;
                dwCtrl[i] <= `RESET_ZERO;
                rwMask[i] <= `RESET_ZERO;
                rwValue[i] <= `RESET_ZERO;
                rwCtrl[i] <= `RESET_ZERO;
            end
        end else if (busWr) begin
            if (selIbA) begin
                ibAddr[sub] <= byteMerge(ibAddr[sub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end else if (selIbC) begin
                ibCtrl[sub] <= byteMerge(ibCtrl[sub], wbDatIn, wbSel, `CTRL_WRITE_MASK);
            end else if (selDw1) begin
                dwFirst[sub] <= byteMerge(dwFirst[sub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end else if (selDw2) begin
                dwSecond[sub] <= byteMerge(dwSecond[sub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end else if (selDwC) begin
                dwCtrl[sub] <= byteMerge(dwCtrl[sub], wbDatIn, wbSel, `DWCTRL_WRITE_MASK);
            end else if (selRwM) begin
                rwMask[sub] <= byteMerge(rwMask[sub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end else if (selRwV) begin
                rwValue[sub] <= byteMerge(rwValue[sub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end else if (selRwC) begin
                rwCtrl[rwSub] <= byteMerge(rwCtrl[rwSub], wbDatIn, wbSel, `CTRL_WRITE_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mailbox, shared by the bus and the configuration port

    // a bus write wins over a configuration write to the same word
    always @(posedge mclk) begin
        if (rst) begin
            for (j = 0; j < MAILBOX_WORDS; j = j + 1) begin
                mailbox[j] <= `RESET_ZERO;
            end
            cfgRdata <= `RESET_ZERO;
        end else begin
            if (cfgEn && cfgWe && !(busWr && selMb && (mbSub == cfgAddr))) begin
                mailbox[cfgAddr] <= cfgWdata;
            end
            if (busWr && selMb) begin
                mailbox[mbSub] <= byteMerge(mailbox[mbSub], wbDatIn, wbSel, 32'hFFFF_FFFF);
            end
            if (cfgEn && !cfgWe) begin
                cfgRdata <= mailbox[cfgAddr];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trap record, debug mode and thread stop

    wire leaveDebug = busWr && selState && wbSel[0] && !wbDatIn[0];
    wire next_debugMode = trapNow || (debugMode && !leaveDebug);
    wire [7:0] next_stop = (busWr && selStop && wbSel[0]) ? wbDatIn[7:0] : stopVector;

    always @(posedge mclk) begin
        if (rst) begin
            cause <= `RESET_ZERO;
            capture <= `RESET_ZERO;
            stopVector <= 8'h00;
            debugMode <= 1'b0;
            debugTrap <= 1'b0;
            threadIssueBlock <= 8'h00;
        end else begin
            debugTrap <= trapNow;
            debugMode <= next_debugMode;
            stopVector <= next_stop;
            // built from next values so a stopped thread gets no issue slot in the cycle after return
            threadIssueBlock <= next_debugMode ? 8'h00 : next_stop;
            if (anyIb) begin
                cause <= {14'h0, lowestHit(ibHit), 5'h0, pcThread, 5'h0, `CAUSE_IBREAK};
            end else if (anyDw) begin
                cause <= {14'h0, lowestHit(dwHit), 5'h0, memThread, 5'h0, `CAUSE_DWATCH};
                capture <= memAddr;
            end else if (anyRw) begin
                cause <= {14'h0, lowestHit(rwHit), 5'h0, resThread, 5'h0, `CAUSE_RWATCH};
                capture <= resId;
            end else begin
                if (busWr && selCause) begin
                    cause <= byteMerge(cause, wbDatIn, wbSel, `CAUSE_WRITE_MASK);
                end
                if (busWr && selCapture) begin
                    capture <= byteMerge(capture, wbDatIn, wbSel, 32'hFFFF_FFFF);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    wire [2:0] evt = {anyRw, anyDw, anyIb};
    wire [2:0] clr = (busWr && selIrqSt && wbSel[0]) ? wbDatIn[2:0] : 3'b000;
    wire [2:0] next_status = (irqStatus & ~clr) | evt;

    always @(posedge mclk) begin
        if (rst) begin
            irqStatus <= 3'b000;
            irqMask <= 3'b000;
            irq <= 1'b0;
        end else begin
            irqStatus <= next_status;
            if (busWr && selIrqMk && wbSel[0]) begin
                irqMask <= wbDatIn[2:0];
            end
            irq <= |(next_status & irqMask);
        end
    end

endmodule // debug_breakpoint_watchpoint_unit
`default_nettype wire

// file: rtl/debug_watch_regs.vh
// register indices, field positions and reset values for the debug watch unit
`ifndef DEBUG_WATCH_REGS_VH
`define DEBUG_WATCH_REGS_VH

// register indices; byte address on the bus is four times the index
`define IDX_CAUSE        8'h15
`define IDX_CAPTURE      8'h16
`define IDX_STOP         8'h18
`define IDX_DBGSTATE     8'h19
`define IDX_IRQ_STATUS   8'h1A
`define IDX_IRQ_MASK     8'h1B
`define IDX_MAILBOX_LO   8'h20
`define IDX_MAILBOX_HI   8'h27
`define IDX_IB_ADDR_LO   8'h30
`define IDX_IB_ADDR_HI   8'h33
`define IDX_IB_CTRL_LO   8'h40
`define IDX_IB_CTRL_HI   8'h43
`define IDX_DW_FIRST_LO  8'h50
`define IDX_DW_FIRST_HI  8'h53
`define IDX_DW_SECOND_LO 8'h60
`define IDX_DW_SECOND_HI 8'h63
`define IDX_DW_CTRL_LO   8'h70
`define IDX_DW_CTRL_HI   8'h73
`define IDX_RW_MASK_LO   8'h80
`define IDX_RW_MASK_HI   8'h83
`define IDX_RW_VALUE_LO  8'h90
`define IDX_RW_VALUE_HI  8'h93
`define IDX_RW_CTRL_LO   8'h9C
`define IDX_RW_CTRL_HI   8'h9F

// control register fields
`define CTRL_ENABLE_BIT  0
`define CTRL_SELECT_BIT  1
`define CTRL_LOAD_BIT    2
`define CTRL_THREAD_LSB  16
`define CTRL_THREAD_MSB  23
`define CTRL_WRITE_MASK  32'h00FF_0003
`define DWCTRL_WRITE_MASK 32'h00FF_0007

// cause register fields and codes
`define CAUSE_CODE_MSB   2
`define CAUSE_THREAD_LSB 8
`define CAUSE_THREAD_MSB 15
`define CAUSE_UNIT_LSB   16
`define CAUSE_UNIT_MSB   17
`define CAUSE_WRITE_MASK 32'h0003_FF07
`define CAUSE_IBREAK     3'h3
`define CAUSE_DWATCH     3'h4
`define CAUSE_RWATCH     3'h5

// interrupt status bits
`define EVT_IBREAK       0
`define EVT_DWATCH       1
`define EVT_RWATCH       2

`define RESET_ZERO       32'h0000_0000
`define STOP_WRITE_MASK  32'h0000_00FF

`endif

// file: verif/debug_breakpoint_watchpoint_unit_bench.sv
// self-checking bench for the debug breakpoint and watchpoint unit
`timescale 1ns/100ps
`default_nettype none
`include "debug_watch_regs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); end end
module debug_breakpoint_watchpoint_unit_bench;
    logic mclk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, cfgEn = 0, cfgWe = 0, go = 0, load = 0;
    logic [9:0] wbAdr = 10'h000;
    logic [2:0] cfgAddr = 3'h0, thr = 3'h0;
    logic [1:0] kind = 2'h0;
    logic [31:0] wbDatIn = 32'h0000_0000, cfgWdata = 32'h0000_0000, val = 32'h0000_0000, q;
    wire [31:0] wbDatOut, cfgRdata, payload;
    wire [7:0] threadIssueBlock;
    wire [2:0] thread;
    wire wbAck, pcValid, memValid, resValid, memIsLoad, debugTrap, debugMode, irq;
    int n_errors = 0, n_tests = 0;
    debug_breakpoint_watchpoint_unit dut (.mclk(mclk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(4'hF), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck), .cfgEn(cfgEn),
        .cfgWe(cfgWe), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata), .pcValid(pcValid),
        .pcThread(thread), .pcValue(payload), .memValid(memValid), .memIsLoad(memIsLoad), .memThread(thread),
        .memAddr(payload), .resValid(resValid), .resThread(thread), .resId(payload), .debugTrap(debugTrap),
        .debugMode(debugMode), .threadIssueBlock(threadIssueBlock), .irq(irq));
    pipeline_model pipe (.mclk(mclk), .go(go), .kind(kind), .thr(thr), .val(val), .load(load), .pcValid(pcValid),
        .memValid(memValid), .resValid(resValid), .memIsLoad(memIsLoad), .thread(thread), .payload(payload));
    initial begin
        forever #5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge mclk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= {idx, 2'b00};
        wbDatIn <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wbAck !== 1'b1);
        `CHK(n, 2)
        q = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0000_0000);
        `CHK(q, e)
    endtask
    // leave debug and clear every sticky event
    task automatic resume;
        wr(`IDX_DBGSTATE, 32'h0000_0000);
        wr(`IDX_IRQ_STATUS, 32'h0000_0007);
    endtask
    task automatic cfg(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfgEn <= 1'b1;
        cfgWe <= w;
        cfgAddr <= a;
        cfgWdata <= d;
        @(posedge mclk);
        cfgEn <= 1'b0;
        #1;
    endtask
    task automatic hit(input logic [1:0] k, input logic [2:0] t, input logic [31:0] v, input logic ld, input logic e);
        @(posedge mclk);
        go <= 1'b1;
        kind <= k;
        thr <= t;
        val <= v;
        load <= ld;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        #1 `CHK(debugTrap, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_errors++;
        $display("wrong value at %0t: timeout", $time);
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(`IDX_IB_CTRL_HI, 32'h0000_0000);
        rd(`IDX_RW_CTRL_HI, 32'h0000_0000);
        rd(8'hFF, 32'h0000_0000);
        wr(`IDX_MAILBOX_HI, 32'hCAFE_0007);
        rd(`IDX_MAILBOX_HI, 32'hCAFE_0007);
        cfg(1'b0, 3'h7, 32'h0000_0000);
        `CHK(cfgRdata, 32'hCAFE_0007)
        cfg(1'b1, 3'h0, 32'h1234_5678);
        rd(`IDX_MAILBOX_LO, 32'h1234_5678);
        wr(`IDX_IB_CTRL_LO, 32'hFFFF_FFFC);
        rd(`IDX_IB_CTRL_LO, 32'h00FF_0000);
        wr(`IDX_IB_ADDR_LO, 32'h0000_1000);
        wr(`IDX_IB_CTRL_LO, 32'h0004_0000);
        hit(2'd0, 3'd2, 32'h0000_1000, 1'b0, 1'b0);
        wr(`IDX_IB_CTRL_LO, 32'h0004_0001);
        wr(`IDX_IRQ_MASK, 32'h0000_0001);
        hit(2'd0, 3'd3, 32'h0000_1000, 1'b0, 1'b0);
        hit(2'd0, 3'd2, 32'h0000_1000, 1'b0, 1'b1);
        `CHK(irq, 1'b1)
        rd(`IDX_CAUSE, 32'h0000_0203);
        wr(`IDX_IRQ_STATUS, 32'h0000_0001);
        @(posedge mclk);
        #1 `CHK(irq, 1'b0)
        resume;
        wr(`IDX_IB_CTRL_LO, 32'h0004_0003);
        hit(2'd0, 3'd2, 32'h0000_1000, 1'b0, 1'b0);
        hit(2'd0, 3'd2, 32'h0000_1004, 1'b0, 1'b1);
        resume;
        wr(`IDX_IB_CTRL_LO, 32'h0000_0000);
        wr(`IDX_IB_ADDR_LO + 8'h01, 32'h0000_2000);
        wr(`IDX_IB_ADDR_LO + 8'h02, 32'h0000_2000);
        wr(`IDX_IB_CTRL_LO + 8'h02, 32'h0004_0001);
        wr(`IDX_IB_CTRL_LO + 8'h01, 32'h0004_0001);
        hit(2'd0, 3'd2, 32'h0000_2000, 1'b0, 1'b1);
        rd(`IDX_CAUSE, 32'h0001_0203);
        resume;
        wr(`IDX_DW_FIRST_LO, 32'h0000_0100);
        wr(`IDX_DW_SECOND_LO, 32'h0000_0200);
        wr(`IDX_DW_CTRL_LO, 32'h0001_0001);
        hit(2'd1, 3'd0, 32'h0000_0200, 1'b0, 1'b0);
        wr(`IDX_DW_CTRL_LO, 32'h0001_0003);
        hit(2'd1, 3'd0, 32'h0000_0100, 1'b1, 1'b0);
        hit(2'd1, 3'd0, 32'h0000_0200, 1'b0, 1'b1);
        rd(`IDX_CAUSE, 32'h0000_0004);
        rd(`IDX_CAPTURE, 32'h0000_0200);
        resume;
        wr(`IDX_DW_CTRL_LO, 32'h0001_0007);
        hit(2'd1, 3'd0, 32'h0000_0100, 1'b1, 1'b1);
        resume;
        wr(`IDX_RW_MASK_LO, 32'h0000_00FF);
        wr(`IDX_RW_VALUE_LO, 32'h0000_0012);
        wr(`IDX_RW_CTRL_LO, 32'h0002_0001);
        hit(2'd2, 3'd1, 32'h0000_AB12, 1'b0, 1'b1);
        rd(`IDX_CAUSE, 32'h0000_0105);
        rd(`IDX_CAPTURE, 32'h0000_AB12);
        resume;
        wr(`IDX_RW_CTRL_LO, 32'h0002_0003);
        hit(2'd2, 3'd1, 32'h0000_AB12, 1'b0, 1'b0);
        hit(2'd2, 3'd1, 32'h0000_0012, 1'b0, 1'b1);
        resume;
        wr(`IDX_STOP, 32'h0000_0105);
        rd(`IDX_STOP, 32'h0000_0005);
        `CHK(threadIssueBlock, 8'h05)
        hit(2'd2, 3'd1, 32'h0000_0012, 1'b0, 1'b1);
        `CHK(threadIssueBlock, 8'h00)
        wr(`IDX_DBGSTATE, 32'h0000_0000);
        `CHK(debugMode, 1'b0)
        `CHK(threadIssueBlock, 8'h05)
        wr(`IDX_IRQ_STATUS, 32'h0000_0007);
        `CHK(threadIssueBlock, 8'h05)
        end_of_test;
    end
endmodule // debug_breakpoint_watchpoint_unit_bench
`default_nettype wire

// file: verif/debug_watch_chk.sv
// assertion checker for the debug breakpoint and watchpoint unit
`timescale 1ns/100ps
`default_nettype none
module debug_watch_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic [31:0] wbDatOut,
    input wire logic wbAck,
    input wire logic pcValid,
    input wire logic memValid,
    input wire logic resValid,
    input wire logic debugTrap,
    input wire logic debugMode,
    input wire logic [7:0] threadIssueBlock,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("request not acked");
    AST_ACK_PULSE: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wbAck |-> wbDatOut == 32'h0000_0000) else $error("read data outside ack");
    AST_TRAP_PULSE: assert property (debugTrap |=> !debugTrap) else $error("trap longer than one cycle");
    AST_TRAP_MODE: assert property (debugTrap |-> debugMode) else $error("trap without debug mode");
    AST_NO_RETRAP: assert property (debugMode |=> !debugTrap) else $error("trap taken in debug mode");
    AST_BLOCK_DEBUG: assert property (debugMode |-> threadIssueBlock == 8'h00)
        else $error("threads blocked in debug");
    AST_TRAP_CAUSE: assert property (!(pcValid || memValid || resValid) |=> !debugTrap)
        else $error("trap without hit");
    AST_MODE_EXIT: assert property ($fell(debugMode) |-> wbAck) else $error("debug mode left without write");
    cover property (debugTrap);
    cover property (irq);
    cover property (wbAck && wbDatOut != 32'h0000_0000);
endmodule // debug_watch_chk
bind debug_breakpoint_watchpoint_unit debug_watch_chk chk (.mclk, .rst, .wbCyc, .wbStb, .wbDatOut, .wbAck,
    .pcValid, .memValid, .resValid, .debugTrap, .debugMode, .threadIssueBlock, .irq);
`default_nettype wire

// file: verif/pipeline_model.sv
// pipeline stand-in issuing one instruction, memory access or resource operation per command
`timescale 1ns/100ps
`default_nettype none
module pipeline_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [2:0] thr,
    input wire logic [31:0] val,
    input wire logic load,
    output logic pcValid = 1'b0,
    output logic memValid = 1'b0,
    output logic resValid = 1'b0,
    output logic memIsLoad = 1'b0,
    output logic [2:0] thread = 3'h0,
    output logic [31:0] payload = 32'h0000_0000
);
    // released lines flip so a stale value can never look like a fresh request
    always @(posedge mclk) begin
        pcValid <= go && kind == 2'd0;
        memValid <= go && kind == 2'd1;
        resValid <= go && kind == 2'd2;
        memIsLoad <= go ? load : !memIsLoad;
        thread <= go ? thr : ~thread;
        payload <= go ? val : ~payload;
    end
endmodule // pipeline_model
`default_nettype wire
